//--- verilog/rx_list_defines.vh
// Purpose: shared constants of the receive list chain walker
// Assumes: 24-bit host byte addresses, 16-bit host memory halfwords
// Notes: included by every design file
`ifndef RX_LIST_DEFINES_VH
`define RX_LIST_DEFINES_VH
// list layout, byte offsets from the list base; pointer offsets from the pair base
`define OFS_LINK_HI 24'h000000
`define OFS_LINK_LO 24'h000002
`define OFS_CSTAT 24'h000004
`define OFS_FSIZE 24'h000006
`define OFS_PAIR0 24'h000008
`define PAIR_STRIDE 24'h000006
`define OFS_PTR_HI 24'h000002
`define OFS_PTR_LO 24'h000004
`define LAST_PAIR 2'h2
// list_command_status bits
`define CST_READY 0
`define CST_COMPLETE 1
`define CST_START 2
`define CST_END 3
// frame layout
`define PAD_MIN_COUNT 16'h0020
`define HDR_LEN 6'h0E
`define PAD_END 6'h20
`define SA_ROUTE_POS 6'h08
`define ROUTE_BIT 7
// register map and fields
`define REG_CTRL 8'h00
`define REG_CHAIN 8'h04
`define REG_DOORBELL 8'h08
`define REG_STATUS 8'h0C
`define REG_CUR_LIST 8'h10
`define CTRL_EN 0
`define CTRL_PAD 1
`define DB_RESUME 0
`define DB_READY 1
`endif

//--- verilog/rx_frame_tracker.v
// Purpose: tracks slot position, routing pad gap and frame length
// Assumes: one slot per written byte or skipped pad byte
// Notes: held cleared while no frame is in progress
`timescale 1ns/1ps
`include "rx_list_defines.vh"
module rx_frame_tracker #(
    parameter LEN_W = 16
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_clear,
    input wire i_slot,
    input wire i_data_slot,
    input wire [7:0] i_data,
    input wire i_pad_en,
    output wire o_pad,
    output reg [LEN_W-1:0] o_len
);
reg [5:0] pos;
reg route;
reg [4:0] rlen;
wire [5:0] route_end = `HDR_LEN + {1'b0, rlen};
// skip slots after the routing field up to 18 bytes, no write
assign o_pad = i_pad_en && (pos >= `HDR_LEN) && (pos < `PAD_END) &&
    (!route || ((pos > `HDR_LEN) && (pos >= route_end)));
// position saturates at the pad end; length counts every slot
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        pos <= 6'h00;
        route <= 1'b0;
        rlen <= 5'h00;
        o_len <= {LEN_W{1'b0}};
    end else if (i_clear) begin
        pos <= 6'h00;
        route <= 1'b0;
        rlen <= 5'h00;
        o_len <= {LEN_W{1'b0}};
    end else if (i_slot) begin
        o_len <= o_len + 1'b1;
        if (pos < `PAD_END) begin
            pos <= pos + 6'h01;
        end
        if (i_data_slot && pos == `SA_ROUTE_POS) begin
            route <= i_data[`ROUTE_BIT];
        end
        if (i_data_slot && pos == `HDR_LEN && route) begin
            rlen <= i_data[4:0];
        end
    end
end
endmodule

//--- verilog/rx_ahb_regs.v
// Purpose: AHB-Lite slave holding control and showing walker state
// Assumes: single word transfers, zero wait states
// Notes: doorbell bits are write-only one-cycle pulses
`timescale 1ns/1ps
`include "rx_list_defines.vh"
module rx_ahb_regs (
    input wire i_clk,
    input wire i_nrst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    input wire [31:0] i_status,
    input wire [23:0] i_cur,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    output reg o_enable,
    output reg o_pad_en,
    output reg [23:0] o_chain,
    output reg o_resume,
    output reg o_ready_req
);
reg wr_pend;
reg [7:0] wr_addr;
wire acc = i_hsel && i_hready && i_htrans[1];
// address phase captured, write data taken in the data phase
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_hrdata <= 32'h00000000;
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
        o_enable <= 1'b0;
        o_pad_en <= 1'b0;
        o_chain <= 24'h000000;
        o_resume <= 1'b0;
        o_ready_req <= 1'b0;
        wr_pend <= 1'b0;
        wr_addr <= 8'h00;
    end else begin
        o_resume <= 1'b0;
        o_ready_req <= 1'b0;
        wr_pend <= acc && i_hwrite;
        if (acc) begin
            wr_addr <= i_haddr[7:0];
        end
        if (wr_pend) begin
            case (wr_addr)
                `REG_CTRL: begin
                    o_enable <= i_hwdata[`CTRL_EN];
                    o_pad_en <= i_hwdata[`CTRL_PAD];
                end
                `REG_CHAIN: o_chain <= i_hwdata[23:0];
                `REG_DOORBELL: begin
                    o_resume <= i_hwdata[`DB_RESUME];
                    o_ready_req <= i_hwdata[`DB_READY];
                end
                default: ;
            endcase
        end
        // read data registered to stand through the data phase
        if (acc && !i_hwrite) begin
            case (i_haddr[7:0])
                `REG_CTRL: o_hrdata <= {30'h00000000, o_pad_en, o_enable};
                `REG_CHAIN: o_hrdata <= {8'h00, o_chain};
                `REG_STATUS: o_hrdata <= i_status;
                `REG_CUR_LIST: o_hrdata <= {8'h00, i_cur};
                default: o_hrdata <= 32'h00000000;
            endcase
        end
    end
end
endmodule

//--- verilog/receive_list_chain_dma.v
// Purpose: walks a chain of receive lists in host memory and scatters frames
// Assumes: host memory port and frame byte stream share i_clk
// Notes: one memory access outstanding at a time
// Function
// - list opens with 32-bit link holding 24-bit next pointer; odd means last
// - after writing a frame into a list, read that list's link
// - odd link raises a more-lists request; receive stays alive
// - at chain end, wait for host resume before the next list
// - lists sit on halfword boundaries; the link is never written
// - frame byte count stored only into the frame-starting list
// - buffer length bounds the bytes written from its pointer; any value
// - at most three pairs per list; a frame may continue into the next list
// - buffer length with bit 0 clear is the list's final pair
// - bit 0 of the third length ignored; third pair always final
// - zero buffer length accepted; nothing written to that buffer
// - with padding on, first length of a start list is at least 32
// - with padding on and first start length below 32, drop padding
// - buffer pointers taken at any byte alignment and never written
// - status written only into frame start list and frame end list
// - odd final link defers status until link even and resume given
// - no data into a list until its ready flag set; host then signals
// - with padding on, routing field padded to 18 bytes, pad not written
`timescale 1ns/1ps
`include "rx_list_defines.vh"
module receive_list_chain_dma #(
    parameter LEN_W = 16
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    output wire [31:0] o_hrdata,
    output wire o_hreadyout,
    output wire o_hresp,
    output reg o_mem_req,
    output reg o_mem_we,
    output reg o_mem_byte,
    output reg [23:0] o_mem_addr,
    output reg [15:0] o_mem_wdata,
    input wire i_mem_ack,
    input wire [15:0] i_mem_rdata,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire i_rx_last,
    output reg o_rx_ready,
    output reg o_need_lists,
    output reg o_frame_done
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam S_IDLE = 13'h0001;
localparam S_CSTAT = 13'h0002;
localparam S_WAIT_RDY = 13'h0004;
localparam S_COUNT = 13'h0008;
localparam S_PTR_HI = 13'h0010;
localparam S_PTR_LO = 13'h0020;
localparam S_DATA = 13'h0040;
localparam S_LINK_HI = 13'h0080;
localparam S_LINK_LO = 13'h0100;
localparam S_STALL = 13'h0200;
localparam S_WR_SIZE = 13'h0400;
localparam S_WR_CS = 13'h0800;
localparam S_WR_CE = 13'h1000;

reg [12:0] state;
reg [23:0] base;
reg [23:0] start_base;
reg [23:0] link;
reg [1:0] pair;
reg [15:0] cap;
reg final_pair;
reg [23:0] wptr;
reg in_frame;
reg is_start;
reg frame_end;
reg byte_last;
reg cancel;
reg [15:0] frames;

wire enable;
wire pad_on;
wire [23:0] chain;
wire resume;
wire ready_req;
wire pad;
wire [LEN_W-1:0] frame_len;

// ----------------------------------------------------------------
// register slave
// ----------------------------------------------------------------
wire [31:0] status_word = {13'h0000, (state != S_IDLE),
    (state == S_WAIT_RDY), o_need_lists, frames};

rx_ahb_regs u_regs (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .i_hwdata(i_hwdata),
    .i_status(status_word),
    .i_cur(base),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_enable(enable),
    .o_pad_en(pad_on),
    .o_chain(chain),
    .o_resume(resume),
    .o_ready_req(ready_req)
);

// ----------------------------------------------------------------
// frame layout tracking
// ----------------------------------------------------------------
wire data_ack = (state == S_DATA) && o_mem_req && i_mem_ack;
wire pad_skip = (state == S_DATA) && !frame_end && (cap != 16'h0000) &&
    pad && !o_mem_req && !o_rx_ready;

rx_frame_tracker #(
    .LEN_W(LEN_W)
) u_track (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_clear(!in_frame),
    .i_slot(data_ack || pad_skip),
    .i_data_slot(data_ack),
    .i_data(o_mem_wdata[7:0]),
    .i_pad_en(pad_on && !cancel),
    .o_pad(pad),
    .o_len(frame_len)
);

// ----------------------------------------------------------------
// list field addressing and write-back values
// ----------------------------------------------------------------
// i_hsize ignored: whole-word transfers only
wire [23:0] pair_base = base + `OFS_PAIR0 + ({22'h000000, pair} * `PAIR_STRIDE);
wire same_list = (base == start_base);
wire [15:0] cst_start = (16'h0001 << `CST_COMPLETE) | (16'h0001 << `CST_START) |
    (same_list ? (16'h0001 << `CST_END) : 16'h0000);
wire [15:0] cst_end = (16'h0001 << `CST_COMPLETE) | (16'h0001 << `CST_END);
wire acc_state = (state == S_CSTAT) || (state == S_COUNT) ||
    (state == S_PTR_HI) || (state == S_PTR_LO) || (state == S_LINK_HI) ||
    (state == S_LINK_LO) || (state == S_WR_SIZE) || (state == S_WR_CS) ||
    (state == S_WR_CE);
wire acc_done = acc_state && o_mem_req && i_mem_ack;
reg [23:0] acc_addr;
reg [15:0] acc_wdata;
reg acc_we;

// choose address and data of the list access for the current state
always @* begin
    acc_addr = base;
    acc_wdata = 16'h0000;
    acc_we = 1'b0;
    case (state)
        S_CSTAT: acc_addr = base + `OFS_CSTAT;
        S_COUNT: acc_addr = pair_base;
        S_PTR_HI: acc_addr = pair_base + `OFS_PTR_HI;
        S_PTR_LO: acc_addr = pair_base + `OFS_PTR_LO;
        S_LINK_HI: acc_addr = base + `OFS_LINK_HI;
        S_LINK_LO: acc_addr = base + `OFS_LINK_LO;
        S_WR_SIZE: begin
            acc_addr = start_base + `OFS_FSIZE;
            acc_wdata = frame_len[15:0];
            acc_we = 1'b1;
        end
        S_WR_CS: begin
            acc_addr = start_base + `OFS_CSTAT;
            acc_wdata = cst_start;
            acc_we = 1'b1;
        end
        S_WR_CE: begin
            acc_addr = base + `OFS_CSTAT;
            acc_wdata = cst_end;
            acc_we = 1'b1;
        end
        default: acc_addr = base;
    endcase
end

// ----------------------------------------------------------------
// chain walker
// ----------------------------------------------------------------
// the link words are only ever read, never in the write-back set
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        state <= S_IDLE;
        o_mem_req <= 1'b0;
        o_mem_we <= 1'b0;
        o_mem_byte <= 1'b0;
        o_mem_addr <= 24'h000000;
        o_mem_wdata <= 16'h0000;
        o_rx_ready <= 1'b0;
        o_need_lists <= 1'b0;
        o_frame_done <= 1'b0;
        base <= 24'h000000;
        start_base <= 24'h000000;
        link <= 24'h000000;
        pair <= 2'h0;
        cap <= 16'h0000;
        final_pair <= 1'b0;
        wptr <= 24'h000000;
        in_frame <= 1'b0;
        is_start <= 1'b0;
        frame_end <= 1'b0;
        byte_last <= 1'b0;
        cancel <= 1'b0;
        frames <= 16'h0000;
    end else begin
        o_frame_done <= 1'b0;
        if (o_mem_req && i_mem_ack) begin
            o_mem_req <= 1'b0;
        end
        if (!enable && !o_mem_req) begin
            // closing drops any partial frame; finish an access first
            state <= S_IDLE;
            o_rx_ready <= 1'b0;
            o_need_lists <= 1'b0;
            in_frame <= 1'b0;
            frame_end <= 1'b0;
            cancel <= 1'b0;
        end else begin
            if (acc_state && !o_mem_req) begin
                o_mem_req <= 1'b1;
                o_mem_addr <= acc_addr;
                o_mem_we <= acc_we;
                o_mem_byte <= 1'b0;
                o_mem_wdata <= acc_wdata;
            end
            case (state)
                S_IDLE: begin
                    if (enable) begin
                        base <= chain;
                        state <= S_CSTAT;
                    end
                end
                S_CSTAT: begin
                    if (acc_done) begin
                        if (i_mem_rdata[`CST_READY]) begin
                            is_start <= !in_frame;
                            if (!in_frame) begin
                                start_base <= base;
                            end
                            pair <= 2'h0;
                            state <= S_COUNT;
                        end else begin
                            state <= S_WAIT_RDY;
                        end
                    end
                end
                S_WAIT_RDY: begin
                    // ready flag is fetched again once the host signals
                    if (ready_req) begin
                        state <= S_CSTAT;
                    end
                end
                S_COUNT: begin
                    if (acc_done) begin
                        cap <= i_mem_rdata;
                        final_pair <= !i_mem_rdata[0] ||
                            (pair == `LAST_PAIR);
                        if (pair == 2'h0 && is_start) begin
                            cancel <= (i_mem_rdata < `PAD_MIN_COUNT);
                        end
                        state <= S_PTR_HI;
                    end
                end
                S_PTR_HI: begin
                    if (acc_done) begin
                        wptr[23:16] <= i_mem_rdata[7:0];
                        state <= S_PTR_LO;
                    end
                end
                S_PTR_LO: begin
                    if (acc_done) begin
                        wptr[15:0] <= i_mem_rdata;
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (frame_end || (cap == 16'h0000 && final_pair)) begin
                        state <= S_LINK_HI;
                    end else if (cap == 16'h0000) begin
                        // non-final buffer exhausted: move to next pair
                        pair <= pair + 2'h1;
                        state <= S_COUNT;
                    end else if (o_mem_req) begin
                        if (i_mem_ack) begin
                            wptr <= wptr + 24'h000001;
                            cap <= cap - 16'h0001;
                            frame_end <= byte_last;
                        end
                    end else if (o_rx_ready) begin
                        if (i_rx_valid) begin
                            o_rx_ready <= 1'b0;
                            in_frame <= 1'b1;
                            byte_last <= i_rx_last;
                            o_mem_req <= 1'b1;
                            o_mem_we <= 1'b1;
                            o_mem_byte <= 1'b1;
                            o_mem_addr <= wptr;
                            o_mem_wdata <= {8'h00, i_rx_data};
                        end
                    end else if (pad) begin
                        // pad slot uses buffer room, writes nothing
                        wptr <= wptr + 24'h000001;
                        cap <= cap - 16'h0001;
                    end else begin
                        o_rx_ready <= 1'b1;
                    end
                end
                S_LINK_HI: begin
                    if (acc_done) begin
                        link[23:16] <= i_mem_rdata[7:0];
                        state <= S_LINK_LO;
                    end
                end
                S_LINK_LO: begin
                    if (acc_done) begin
                        link[15:0] <= i_mem_rdata;
                        if (i_mem_rdata[0]) begin
                            o_need_lists <= 1'b1;
                            state <= S_STALL;
                        end else if (frame_end) begin
                            state <= S_WR_SIZE;
                        end else begin
                            base <= {link[23:16], i_mem_rdata};
                            state <= S_CSTAT;
                        end
                    end
                end
                S_STALL: begin
                    // link re-read: the host has just extended it
                    if (resume) begin
                        o_need_lists <= 1'b0;
                        state <= S_LINK_HI;
                    end
                end
                S_WR_SIZE: begin
                    if (acc_done) begin
                        state <= S_WR_CS;
                    end
                end
                S_WR_CS: begin
                    if (acc_done) begin
                        if (same_list) begin
                            state <= S_CSTAT;
                            base <= link;
                            frames <= frames + 16'h0001;
                            o_frame_done <= 1'b1;
                            in_frame <= 1'b0;
                            frame_end <= 1'b0;
                            cancel <= 1'b0;
                        end else begin
                            state <= S_WR_CE;
                        end
                    end
                end
                S_WR_CE: begin
                    if (acc_done) begin
                        state <= S_CSTAT;
                        base <= link;
                        frames <= frames + 16'h0001;
                        o_frame_done <= 1'b1;
                        in_frame <= 1'b0;
                        frame_end <= 1'b0;
                        cancel <= 1'b0;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

endmodule

//--- sim/rx_host_mem_model.sv
// Purpose: host memory behind the walker's memory port
// Assumes: byte array, big-endian halfwords, 4 KB window
// Notes: read data flips every idle cycle so stale data never matches
`timescale 1ns/1ps
module rx_host_mem_model (
    input wire i_clk,
    input wire i_slow,
    input wire i_req,
    input wire i_we,
    input wire i_byte,
    input wire [23:0] i_addr,
    input wire [15:0] i_wdata,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [7:0] m [0:4095];
    logic [2:0] cnt;
    wire [11:0] a = i_addr[11:0];
    initial begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        cnt = 3'h0;
        for (int k = 0; k < 4096; k++) m[k] = 8'hEE;
    end
    // slow mode answers after three cycles
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt >= (i_slow ? 3'h2 : 3'h0)) begin
                cnt <= 3'h0;
                o_ack <= 1'b1;
                if (!i_we) o_rdata <= {m[a], m[a + 12'h1]};
                else if (i_byte) m[a] <= i_wdata[7:0];
                else {m[a], m[a + 12'h1]} <= i_wdata;
            end
        end
    end
endmodule

//--- sim/receive_list_chain_dma_sva.sv
// Purpose: port-level checks of the receive list walker
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the testbench
`timescale 1ns/1ps
module receive_list_chain_dma_sva (
    input wire i_clk,
    input wire i_nrst,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire o_mem_req,
    input wire o_mem_we,
    input wire o_mem_byte,
    input wire [23:0] o_mem_addr,
    input wire [15:0] o_mem_wdata,
    input wire i_mem_ack,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire o_rx_ready,
    input wire o_need_lists,
    input wire o_frame_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------
    // memory port and byte stream
    // ------------------------------------
    AST_HALF_ALIGN: assert property (o_mem_req && !o_mem_byte |-> !o_mem_addr[0])
        else $error("odd halfword address");
    AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack |=>
        o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata))
        else $error("request changed before ack");
    AST_REQ_DROP: assert property (i_mem_ack |=> !o_mem_req)
        else $error("request still up after ack");
    AST_BYTE_WRITE: assert property (
        i_rx_valid && o_rx_ready |=> o_mem_req && o_mem_we && o_mem_byte
        && o_mem_wdata[7:0] == $past(i_rx_data))
        else $error("taken byte not written");
    AST_READY_DROP: assert property (i_rx_valid && o_rx_ready |=> !o_rx_ready)
        else $error("ready stayed up after a byte");
    // a stalled walker stays silent
    AST_STALL_QUIET: assert property (o_need_lists |-> !o_mem_req && !o_rx_ready)
        else $error("activity while stalled");
    AST_DONE_PULSE: assert property (o_frame_done |=> !o_frame_done)
        else $error("frame done too long");
    AST_DONE_NOT_STALLED: assert property (o_frame_done |-> !o_need_lists)
        else $error("status finished while stalled");
    AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or not okay");
endmodule

//--- sim/tb_receive_list_chain_dma.sv
// Purpose: directed test of the receive list walker
// Assumes: memory model answers fast or slow
// Notes: lists and buffers sit below 4 KB
`timescale 1ns/1ps
module tb_receive_list_chain_dma;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, slow = 1'b0;
    logic i_rx_valid = 1'b0, i_rx_last = 1'b0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
    logic [1:0] i_htrans = 2'h0;
    logic [7:0] i_rx_data = 8'h00;
    wire [31:0] o_hrdata;
    wire [23:0] o_mem_addr;
    wire [15:0] o_mem_wdata, mem_rdata;
    wire o_hreadyout, o_hresp, o_mem_req, o_mem_we, o_mem_byte, mem_ack;
    wire o_rx_ready, o_need_lists, o_frame_done;
    int fail_count = 0, cmp_count = 0;
    logic [11:0] g [4] = '{12'h306, 12'h330, 12'h342, 12'h34A};
    always #2.5 i_clk = ~i_clk;
    receive_list_chain_dma dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hready(o_hreadyout), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_mem_req(o_mem_req),
        .o_mem_we(o_mem_we), .o_mem_byte(o_mem_byte), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last),
        .o_rx_ready(o_rx_ready), .o_need_lists(o_need_lists), .o_frame_done(o_frame_done));
    rx_host_mem_model mem_u (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_byte(o_mem_byte), .i_addr(o_mem_addr),
        .i_wdata(o_mem_wdata), .o_ack(mem_ack), .o_rdata(mem_rdata));
    // ------------------------------------
    // helpers
    // ------------------------------------
    task ck(input string n, input [31:0] g, input [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // single AHB transfer; read data taken at data phase end
    task ahb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        i_hsel <= 1'b1;
        i_haddr <= {24'h0, a};
        i_hwrite <= w;
        i_htrans <= 2'h2;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        q = o_hrdata;
    endtask
    task put(input [11:0] a, input [15:0] v);
        mem_u.m[a] = v[15:8];
        mem_u.m[a + 12'h1] = v[7:0];
    endtask
    function [15:0] get(input [11:0] a);
        return {mem_u.m[a], mem_u.m[a + 12'h1]};
    endfunction
    // host builds a list: link, ready flag, three pairs
    task mk(input [11:0] b, input [15:0] lk, cs, input [15:0] n [3], p [3]);
        put(b, 16'h0000);
        put(b + 12'h2, lk);
        put(b + 12'h4, cs);
        put(b + 12'h6, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            put(b + 12'(8 + 6 * k), n[k]);
            put(b + 12'(10 + 6 * k), 16'h0000);
            put(b + 12'(12 + 6 * k), p[k]);
        end
    endtask
    task frame(input [7:0] b0, input int n);
        for (int i = 0; i < n; i++) begin
            i_rx_valid <= 1'b1;
            i_rx_data <= b0 + 8'(i);
            i_rx_last <= (i == n - 1);
            do @(posedge i_clk); while (o_rx_ready !== 1'b1);
        end
        i_rx_valid <= 1'b0;
        i_rx_last <= 1'b0;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        logic [31:0] q;
        logic [11:0] a;
        int n;
        repeat (8) @(posedge i_clk);
        mk(12'h100, 16'h0140, 16'h1, '{16'h5, 16'h4, 16'h0}, '{16'h301, 16'h310, 16'h0});
        mk(12'h140, 16'h0180, 16'h1, '{16'h3, 16'h0, 16'h0}, '{16'h321, 16'h330, 16'h0});
        mk(12'h180, 16'h0001, 16'h1, '{16'h1, 16'h1, 16'h1}, '{16'h341, 16'h345, 16'h349});
        mk(12'h1C0, 16'h0001, 16'h0, '{16'h2, 16'h0, 16'h0}, '{16'h361, 16'h0, 16'h0});
        i_nrst <= 1'b1;
        @(posedge i_clk);
        ahb(1'b0, 8'h00, 32'h0, q);
        ck("ctrl reset", q, 32'h0);
        ahb(1'b0, 8'h14, 32'h0, q);
        ck("unmapped read", q, 32'h0);
        ahb(1'b1, 8'h04, 32'h100, q);
        ahb(1'b0, 8'h04, 32'h0, q);
        ck("chain", q, 32'h100);
        ahb(1'b1, 8'h00, 32'h1, q);
        frame(8'h10, 9);
        slow <= 1'b1;
        frame(8'h20, 6);
        for (n = 0; n < 3000 && o_need_lists !== 1'b1; n++) @(posedge i_clk);
        ahb(1'b0, 8'h0C, 32'h0, q);
        ck("stall flag", q[16], 1'b1);
        ck("deferred status", get(12'h144), 16'h0001);
        put(12'h180, 16'h0000);
        @(posedge i_clk);
        put(12'h182, 16'h01C0);
        ahb(1'b1, 8'h08, 32'h1, q);
        for (n = 0; n < 3000 && o_frame_done !== 1'b1; n++) @(posedge i_clk);
        @(posedge i_clk);
        for (int i = 0; i < 15; i++) begin
            a = 12'(i < 5 ? 'h301 + i : i < 9 ? 'h30B + i : i < 12 ? 'h318 + i : 'h311 + 4 * i);
            ck("buffer byte", mem_u.m[a], 8'(i < 9 ? 'h10 + i : 'h17 + i));
        end
        for (int k = 0; k < 4; k++) ck("guard byte", mem_u.m[g[k]], 8'hEE);
        ck("size A", get(12'h106), 16'h9);
        ck("cstat A", get(12'h104), 16'hE);
        ck("size B", get(12'h146), 16'h6);
        ck("cstat B", get(12'h144), 16'h6);
        ck("size C", get(12'h186), 16'h0);
        ck("cstat C", get(12'h184), 16'hA);
        ck("link A", get(12'h102), 16'h0140);
        ck("pointer C", get(12'h18C), 16'h0341);
        ahb(1'b0, 8'h0C, 32'h0, q);
        ck("status", q[16:0], 17'h2);
        repeat (20) @(posedge i_clk);
        ck("ready held", o_rx_ready, 1'b0);
        put(12'h1C4, 16'h0001);
        ahb(1'b1, 8'h08, 32'h2, q);
        for (n = 0; n < 500 && o_rx_ready !== 1'b1; n++) @(posedge i_clk);
        ck("ready after flag", o_rx_ready, 1'b1);
        tally_and_finish;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        tally_and_finish;
    end
endmodule
bind receive_list_chain_dma receive_list_chain_dma_sva chk_u (.*);
